// ---- dv/ipsc_sink_model.sv ----
/*
  Frame buffer side of the image port: captures qualified bytes, drives gate.
  Assumes the bench supplies the clock and a hold request.
*/
`timescale 1ns/1ps
`default_nettype none
module ipsc_sink_model (
  // Clock and stall request
  input  wire logic       CORE_CLK,
  input  wire logic       hold,
  // Image port
  input  wire logic [7:0] PORT_DATA,
  input  wire logic       OUTPUT_QUALIFIER_PIN,
  output logic            SINK_READY_GATE,
  // Captured bytes
  output logic            cap_vld,
  output logic [7:0]      cap_byte
);
  assign SINK_READY_GATE = ~hold;
  // Every cycle is registered; cap_vld marks the qualified ones
  always @(posedge CORE_CLK) begin
    cap_vld  <= OUTPUT_QUALIFIER_PIN;
    cap_byte <= PORT_DATA;
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
/*
  Self-checking bench of the image port stream coder: register reads, video
  lines in every code kind, three text packets under random sink stalls.
  Assumes CE held high and a sink model capturing qualified bytes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ipsc_consts.svh"
module testbench;
  logic CORE_CLK = 0, RST = 1, CE = 1, AVS_READ = 0, AVS_WRITE = 0, hold = 0;
  logic VID_LINE_REQ = 0, VID_LINE_VBLANK = 0, VID_LINE_LAST = 0, VID_FIELD = 0;
  logic VID_TASK_B = 0, VID_FIFO_PENDING = 0, VID_VALID = 0, VID_END = 0;
  logic TXT_REQ = 0, TXT_FIELD = 0, TXT_VALID = 0, AVS_WAITREQUEST, VID_READY;
  logic TXT_READY, TXT_DONE, SINK_READY_GATE, OUTPUT_QUALIFIER_PIN, cap_vld;
  logic HORIZONTAL_GATE_PIN, VERTICAL_GATE_PIN, GENERAL_FLAG_PIN_A, GENERAL_FLAG_PIN_B;
  logic [4:0]  AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
  logic [3:0]  AVS_BYTEENABLE = 0, TXT_TYPE = 0;
  logic [8:0]  TXT_LINE = 0;
  logic [5:0]  TXT_COUNT = 0;
  logic [7:0]  VID_DATA = 0, TXT_DATA = 0, PORT_DATA, cap_byte, seed = 8'h15, gs = 8'h15;
  logic [7:0]  pix [64], expq [$];
  int          vi, vn, ti, tn, errors = 0, checked = 0, cyc = 0;
  // Ctrl, {task b, vblank, last, field}, start code, end code
  localparam logic [23:0] VT [7] = '{24'h200000, 24'h10809d, 24'h13c7f1,
    24'h14abb6, 24'h514954, 24'h55627f, 24'h980e13};

  ipsc_top #(.BURST_LEN(2)) i_ipsc_top (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .VID_LINE_REQ(VID_LINE_REQ), .VID_LINE_VBLANK(VID_LINE_VBLANK),
    .VID_LINE_LAST(VID_LINE_LAST), .VID_FIELD(VID_FIELD), .VID_TASK_B(VID_TASK_B),
    .VID_FIFO_PENDING(VID_FIFO_PENDING), .VID_VALID(VID_VALID), .VID_DATA(VID_DATA),
    .VID_END(VID_END), .VID_READY(VID_READY), .TXT_REQ(TXT_REQ), .TXT_FIELD(TXT_FIELD),
    .TXT_LINE(TXT_LINE), .TXT_TYPE(TXT_TYPE), .TXT_COUNT(TXT_COUNT),
    .TXT_VALID(TXT_VALID), .TXT_DATA(TXT_DATA), .TXT_READY(TXT_READY),
    .TXT_DONE(TXT_DONE), .SINK_READY_GATE(SINK_READY_GATE), .PORT_DATA(PORT_DATA),
    .OUTPUT_QUALIFIER_PIN(OUTPUT_QUALIFIER_PIN), .HORIZONTAL_GATE_PIN(HORIZONTAL_GATE_PIN),
    .VERTICAL_GATE_PIN(VERTICAL_GATE_PIN), .GENERAL_FLAG_PIN_A(GENERAL_FLAG_PIN_A),
    .GENERAL_FLAG_PIN_B(GENERAL_FLAG_PIN_B));
  ipsc_sink_model i_ipsc_sink_model (.CORE_CLK(CORE_CLK), .hold(hold),
    .PORT_DATA(PORT_DATA), .OUTPUT_QUALIFIER_PIN(OUTPUT_QUALIFIER_PIN),
    .SINK_READY_GATE(SINK_READY_GATE), .cap_vld(cap_vld), .cap_byte(cap_byte));

  always #5 CORE_CLK = ~CORE_CLK;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] pb(input logic [5:0] v);
    return {~^v, ^v, v};
  endfunction
  function automatic logic [7:0] ob(input logic [6:0] v);
    return {~^v, v};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pre(input logic [7:0] c, input logic a = 1'b0);
    expq.push_back(a ? 8'h00 : 8'hff);
    expq.push_back(a ? 8'hff : 8'h00);
    expq.push_back(a ? 8'hff : 8'h00);
    expq.push_back(c);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    @(posedge CORE_CLK);
    AVS_WRITE <= w; AVS_READ <= !w; AVS_ADDRESS <= a; AVS_WRITEDATA <= d; AVS_BYTEENABLE <= be;
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA;
    AVS_WRITE <= 0; AVS_READ <= 0;
  endtask
  task automatic drain;
    while (expq.size() != 0) @(posedge CORE_CLK);
    repeat (6) @(posedge CORE_CLK);
  endtask
  task automatic vline(input logic [23:0] c);
    logic [31:0] r;
    int n;
    n = 1 + seed[2:0];
    bus(1, `IPSC_ADDR_CTRL, c[23:20], 4'h1, r);
    for (int i = 0; i < n; i++) begin seed = lf(seed); pix[i] = seed; end
    if (c[20]) pre(c[15:8]);
    for (int i = 0; i < n; i++) expq.push_back(pix[i]);
    if (c[20]) pre(c[7:0]);
    @(posedge CORE_CLK);
    {VID_TASK_B, VID_LINE_VBLANK, VID_LINE_LAST, VID_FIELD} <= c[19:16];
    VID_LINE_REQ <= 1; VID_VALID <= 1; VID_DATA <= pix[0]; VID_END <= (n == 1); vi <= 0; vn <= n;
    drain;
  endtask
  task automatic tpkt(input logic [5:0] ancillary_id_field, input logic fld, input int n,
                      input logic [7:0] sav, input logic [7:0] eav, input logic pend);
    logic [31:0] r;
    logic [7:0]  cs, sd, q [$];
    logic [8:0]  ln;
    logic [5:0]  dc;
    sd = seed[5:0]; ln = {seed[0], seed}; cs = 0;
    dc = (ancillary_id_field < 6'h3e) ? 6'((n + 5) / 4) : 6'h0b;
    bus(1, `IPSC_ADDR_CTRL, 32'h1, 4'h1, r);
    bus(1, `IPSC_ADDR_DID, ancillary_id_field, 4'h1, r);
    bus(1, `IPSC_ADDR_SLICE_SOURCE_TAG, sd, 4'h1, r);
    q = {sav, pb(sd[5:0]), pb(dc), ob({fld, ln[8:3]}), ob({ln[2:0], seed[3:0]})};
    for (int i = 0; i < n; i++) begin seed = lf(seed); pix[i] = seed; q.push_back(seed); end
    for (int i = n; i < 4 * dc - 2; i++) q.push_back(8'ha0);
    pre(q.pop_front(), ancillary_id_field < 6'h3e);
    cs = sav;
    foreach (q[i]) begin cs += q[i]; expq.push_back(q[i]); end
    expq.push_back({cs[6], cs[6:0]});
    expq.push_back(ob({1'b0, 6'(n + 2)}));
    if (ancillary_id_field >= 6'h3e) pre(eav);
    @(posedge CORE_CLK);
    TXT_FIELD <= fld; TXT_LINE <= ln; TXT_TYPE <= sd[3:0]; TXT_COUNT <= n[5:0]; TXT_REQ <= 1;
    TXT_VALID <= 1; TXT_DATA <= pix[0]; ti <= 0; tn <= n; VID_FIFO_PENDING <= pend;
    repeat (20) @(posedge CORE_CLK);
    chk("text held while video pending", !pend, GENERAL_FLAG_PIN_A);
    VID_FIFO_PENDING <= 0;
    drain;
    chk("sliced flag", 1, GENERAL_FLAG_PIN_A);
    chk("flag b sliced", 1, GENERAL_FLAG_PIN_B);
  endtask

  // Sources answer the coder's ready
  always @(posedge CORE_CLK) begin
    gs <= lf(gs);
    hold <= TXT_REQ && gs[0];
    if (VID_VALID && VID_READY) begin
      VID_END <= (vi + 2 == vn); VID_DATA <= pix[vi + 1]; vi <= vi + 1;
      if (VID_END) begin VID_VALID <= 0; VID_LINE_REQ <= 0; end
    end
    if (TXT_VALID && TXT_READY) begin
      TXT_DATA <= pix[ti + 1]; ti <= ti + 1;
      if (ti + 1 == tn) TXT_VALID <= 0;
    end
    if (TXT_DONE) TXT_REQ <= 0;
  end
  // Compare captured bytes against the oldest note
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 30000) begin errors++; finish_test; end
    if (!RST && cap_vld === 1'b1) begin
      if (expq.size() == 0) chk("unexpected port byte", 32'h100, cap_byte);
      else chk("port byte", expq.pop_front(), cap_byte);
    end
    if (!RST && OUTPUT_QUALIFIER_PIN === 1'b0) chk("idle byte", 0, PORT_DATA);
  end

  task automatic finish_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    repeat (8) @(posedge CORE_CLK);
    RST <= 0;
    bus(1, `IPSC_ADDR_DID, 32'h3f, 4'h0, r);
    bus(0, `IPSC_ADDR_CTRL, 0, 4'hf, r); chk("ctrl", `IPSC_CTRL_RST, r);
    bus(0, `IPSC_ADDR_DID, 0, 4'hf, r); chk("did", `IPSC_DID_RST, r);
    bus(0, `IPSC_ADDR_POL, 0, 4'hf, r); chk("pol", `IPSC_POL_RST, r);
    bus(0, 5'h1c, 0, 4'hf, r); chk("unmapped", 0, r);
    foreach (VT[i]) vline(VT[i]);
    tpkt(6'h3e, 0, 5, 8'hab, 8'hb6, 1);
    tpkt(6'h3f, 1, 42, 8'h62, 8'h7f, 0);
    tpkt(6'h15, 0, 9, 8'h55, 8'h00, 0);
    vline(VT[1]);
    chk("sliced flag", 0, GENERAL_FLAG_PIN_A);
    chk("vertical gate", 1, VERTICAL_GATE_PIN);
    finish_test;
  end
endmodule
`default_nettype wire

// ---- hw/ipsc_consts.svh ----
/*
  Constants of the image port stream coder: register offsets, reset values,
  fixed byte values of the output coding and the burst length.
  Assumes inclusion by bare name from the design files.
*/
`ifndef IPSC_CONSTS_SVH
`define IPSC_CONSTS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define IPSC_ADDR_CTRL      5'h00
`define IPSC_ADDR_DID       5'h04
`define IPSC_ADDR_SLICE_SOURCE_TAG      5'h08
`define IPSC_ADDR_POL       5'h0c
`define IPSC_ADDR_FSEL      5'h10
`define IPSC_ADDR_STATUS    5'h14

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define IPSC_CTRL_CODES_EN  0
`define IPSC_CTRL_TRIG      1
`define IPSC_CTRL_PAGE_A    2
`define IPSC_CTRL_PAGE_B    3
`define IPSC_CTRL_RST       4'h1
`define IPSC_DID_RST        6'h3e
`define IPSC_SLICE_SOURCE_TAG_RST       6'h00
`define IPSC_POL_RST        5'h00
`define IPSC_FSEL_RST       4'h0

// ********************************************************************
// Output coding values
// ********************************************************************
`define IPSC_BYTE_INVALID   8'h00
`define IPSC_BYTE_FF        8'hff
`define IPSC_PAD_BYTE       8'ha0
`define IPSC_DC_CODES       6'h0b
`define IPSC_DID_MSB1       6'h3e
`define IPSC_ID_BYTES       8'h02
// Timing code bytes, index {msb, kind[1:0], field}, entry 0 in low byte
`define IPSC_CODE_LUT       128'hf1b6_ecab_da9d_c780_7f38_6225_5413_490e

// ********************************************************************
// Timing counts
// ********************************************************************
`define IPSC_BURST_LEN      8

`endif

// ---- hw/ipsc_pkg.sv ----
/*
  Types of the image port stream coder: arbiter states, timing code kinds
  and flag pin selections.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ipsc_pkg;

  // Gray coded along IDLE, PRE, VPIX and HDR, TDAT, TTRL
  typedef enum logic [2:0] {
    IPSC_ST_IDLE = 3'h0,
    IPSC_ST_PRE  = 3'h1,
    IPSC_ST_VPIX = 3'h3,
    IPSC_ST_HDR  = 3'h2,
    IPSC_ST_TDAT = 3'h6,
    IPSC_ST_TTRL = 3'h7
  } ipsc_state_t;

  typedef enum logic [1:0] {
    IPSC_K_SAV_ACT = 2'h0,
    IPSC_K_EAV_ACT = 2'h1,
    IPSC_K_SAV_VBL = 2'h2,
    IPSC_K_EAV_VBL = 2'h3
  } ipsc_kind_t;

  typedef enum logic [1:0] {
    IPSC_F_SLICED = 2'h0,
    IPSC_F_HGATE  = 2'h1,
    IPSC_F_VGATE  = 2'h2,
    IPSC_F_QUAL   = 2'h3
  } ipsc_fsel_t;

endpackage

// ---- hw/ipsc_top.sv ----
/*
  Image port stream coder: arbitrates video lines and sliced text lines onto
  one byte bus, inserts timing codes, frames text packets and drives the
  qualifier, gate and flag pins. Registers over Avalon-MM with waitrequest.
  Assumes video and text sources on CORE_CLK; only SINK_READY_GATE is a pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ipsc_consts.svh"

// Summary of operation
// - Text only between video lines, no pending video
// - Gate signals frame data, or rising-edge triggers
// - Qualifier with data; invalid cycles carry 00
// - Timing codes can be suppressed
// - Sink gate holds output; bursts of fixed length
// - Signals mappable to pins, polarity programmable
// - Active line start code 0E/49/80/C7
// - Active line end code 13/54/9D/DA
// - Last active or blanking end 38/7F/B6/F1
// - Preamble FF 00 00 before each code
// - Video code MSB is inverted page select
// - Text code MSB 1 for 3E, 0 for 3F
// - Source tag byte: six bits plus parities
// - Code framing: Dword count fixed 4B
// - Ancillary framing: count is (n+5)/4
// - ID bytes: parity, field, line, type
// - Code framing pads unused bytes with A0
// - Checksum from code byte to last data or pad byte
// - Byte count counts valid bytes from ID1
// - Even/inverted parity; ID bytes odd parity
// - Sliced flag: set on first text byte, clear on SAV
// - Field bit 0/1; V=0 active, H=0 start
module ipsc_top
  import ipsc_pkg::*;
#(
  parameter int BURST_LEN = `IPSC_BURST_LEN
) (
  // Clock, reset, enable
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Scaled video source
  input  wire logic        VID_LINE_REQ,
  input  wire logic        VID_LINE_VBLANK,
  input  wire logic        VID_LINE_LAST,
  input  wire logic        VID_FIELD,
  input  wire logic        VID_TASK_B,
  input  wire logic        VID_FIFO_PENDING,
  input  wire logic        VID_VALID,
  input  wire logic [7:0]  VID_DATA,
  input  wire logic        VID_END,
  output logic             VID_READY,
  // Sliced text source
  input  wire logic        TXT_REQ,
  input  wire logic        TXT_FIELD,
  input  wire logic [8:0]  TXT_LINE,
  input  wire logic [3:0]  TXT_TYPE,
  input  wire logic [5:0]  TXT_COUNT,
  input  wire logic        TXT_VALID,
  input  wire logic [7:0]  TXT_DATA,
  output logic             TXT_READY,
  output logic             TXT_DONE,
  // Image port pins
  input  wire logic        SINK_READY_GATE,
  output logic      [7:0]  PORT_DATA,
  output logic             OUTPUT_QUALIFIER_PIN,
  output logic             HORIZONTAL_GATE_PIN,
  output logic             VERTICAL_GATE_PIN,
  output logic             GENERAL_FLAG_PIN_A,
  output logic             GENERAL_FLAG_PIN_B
);

  if (BURST_LEN < 1 || BURST_LEN > 256) begin : g_chk
    $error("BURST_LEN must lie in 1 to 256");
  end

  localparam logic [7:0] BURST_LOAD = 8'(BURST_LEN - 1);

  // ******************************************************************
  // Parity and lookup functions
  // ******************************************************************
  function automatic logic [7:0] ep_byte(input logic [5:0] d);
    ep_byte = {~(^d), ^d, d};
  endfunction

  function automatic logic [7:0] op_byte(input logic [6:0] d);
    op_byte = {~(^d), d};
  endfunction

  function automatic logic [7:0] code_lut(input logic msb, input ipsc_kind_t k,
                                          input logic field_identifier);
    logic [127:0] lut;
    lut = `IPSC_CODE_LUT;
    code_lut = lut[{msb, k, field_identifier, 3'h0} +: 8];
  endfunction

  function automatic logic flag_mux(input logic [1:0] sel, input logic sl,
                                    input logic hg, input logic vg, input logic q);
    case (sel)
      IPSC_F_SLICED: flag_mux = sl;
      IPSC_F_HGATE:  flag_mux = hg;
      IPSC_F_VGATE:  flag_mux = vg;
      default:       flag_mux = q;
    endcase
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  ipsc_state_t st_r, st_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        eav_r, eav_nxt, txt_r, txt_nxt;
  logic        anc_r, msb_r, fid_r, vbl_r, last_r, tfirst_r;
  logic [7:0]  cs_r, burst_r, data_r;
  logic        qual_r, hgate_r, vgate_r, hprev_r, vprev_r, sl_flag_r;
  logic        gate_m_r, gate_s_r, ack_r;
  logic [3:0]  ctrl_r, fsel_r;
  logic [5:0]  did_r, slice_source_tag_r;
  logic [4:0]  pol_r;
  logic [31:0] rdata_r;

  // ******************************************************************
  // Avalon-MM slave
  // ******************************************************************
  // Every access costs one wait cycle so read data always come from a flop
  wire        req      = AVS_READ | AVS_WRITE;
  wire        acc_done = req & ack_r & CE;
  wire        wr_en    = AVS_WRITE & acc_done & AVS_BYTEENABLE[0];
  wire        sel_ctrl = AVS_ADDRESS == `IPSC_ADDR_CTRL;
  wire        sel_did  = AVS_ADDRESS == `IPSC_ADDR_DID;
  wire        sel_slice_source_tag = AVS_ADDRESS == `IPSC_ADDR_SLICE_SOURCE_TAG;
  wire        sel_pol  = AVS_ADDRESS == `IPSC_ADDR_POL;
  wire        sel_fsel = AVS_ADDRESS == `IPSC_ADDR_FSEL;
  wire        sel_stat = AVS_ADDRESS == `IPSC_ADDR_STATUS;
  wire [31:0] rd_mux   = sel_ctrl ? {28'h0, ctrl_r} :
                         sel_did  ? {26'h0, did_r} :
                         sel_slice_source_tag ? {26'h0, slice_source_tag_r} :
                         sel_pol  ? {27'h0, pol_r} :
                         sel_fsel ? {28'h0, fsel_r} :
                         sel_stat ? {26'h0, st_r, sl_flag_r, vgate_r, hgate_r} : 32'h0;

  assign AVS_WAITREQUEST = req & ~(ack_r & CE);
  assign AVS_READDATA    = rdata_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else if (CE) begin
      ack_r   <= req & ~ack_r;
      rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_r <= `IPSC_CTRL_RST;
      did_r  <= `IPSC_DID_RST;
      slice_source_tag_r <= `IPSC_SLICE_SOURCE_TAG_RST;
      pol_r  <= `IPSC_POL_RST;
      fsel_r <= `IPSC_FSEL_RST;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_r <= AVS_WRITEDATA[3:0];
      if (sel_did)  did_r  <= AVS_WRITEDATA[5:0];
      if (sel_slice_source_tag) slice_source_tag_r <= AVS_WRITEDATA[5:0];
      if (sel_pol)  pol_r  <= AVS_WRITEDATA[4:0];
      if (sel_fsel) fsel_r <= AVS_WRITEDATA[3:0];
    end
  end

  // ******************************************************************
  // Sink gate and burst counter
  // ******************************************************************
  // Once a burst starts it runs to its end even if the gate drops
  wire adv = CE & (gate_s_r | (burst_r != 8'h0));

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      gate_m_r <= 1'b0;
      gate_s_r <= 1'b0;
      burst_r  <= 8'h0;
    end else if (CE) begin
      gate_m_r <= SINK_READY_GATE;
      gate_s_r <= gate_m_r;
      if (burst_r != 8'h0)
        burst_r <= burst_r - 8'h1;
      else if (gate_s_r)
        burst_r <= BURST_LOAD;
    end
  end

  // ******************************************************************
  // Byte selection
  // ******************************************************************
  wire        codes_en   = ctrl_r[`IPSC_CTRL_CODES_EN];
  wire        did_anc    = did_r < `IPSC_DID_MSB1;
  wire [6:0]  anc_dc7    = 7'(({1'b0, TXT_COUNT} + 7'd5) >> 2);
  wire [5:0]  dc_val     = anc_r ? anc_dc7[5:0] : `IPSC_DC_CODES;
  wire [7:0]  region_end = {dc_val, 2'b00} - 8'h1;
  wire [7:0]  valid_n    = {2'b00, TXT_COUNT} + `IPSC_ID_BYTES;
  wire        need_txt   = (st_r == IPSC_ST_TDAT) & (cnt_r >= `IPSC_ID_BYTES)
                           & (cnt_r < valid_n);
  wire        vid_msb    = ~(VID_TASK_B ? ctrl_r[`IPSC_CTRL_PAGE_B]
                                        : ctrl_r[`IPSC_CTRL_PAGE_A]);
  ipsc_kind_t kind;
  assign kind = txt_r ? (eav_r ? IPSC_K_EAV_VBL : IPSC_K_SAV_VBL) :
                eav_r ? ((vbl_r | last_r) ? IPSC_K_EAV_VBL : IPSC_K_EAV_ACT) :
                (vbl_r ? IPSC_K_SAV_VBL : IPSC_K_SAV_ACT);
  wire [7:0]  pre_byte   = anc_r ? ((cnt_r == 8'h0) ? 8'h00 : `IPSC_BYTE_FF)
                                 : ((cnt_r == 8'h0) ? `IPSC_BYTE_FF : 8'h00);
  wire [7:0]  code_byte  = anc_r ? ep_byte(did_r) : code_lut(msb_r, kind, fid_r);
  wire [7:0]  head_byte  = (st_r == IPSC_ST_PRE) ? ((cnt_r == 8'h3) ? code_byte : pre_byte) :
                           (cnt_r == 8'h0) ? ep_byte(slice_source_tag_r) : ep_byte(dc_val);
  wire [7:0]  tdat_byte  = (cnt_r == 8'h0) ? op_byte({fid_r, TXT_LINE[8:3]}) :
                           (cnt_r == 8'h1) ? op_byte({TXT_LINE[2:0], TXT_TYPE}) :
                           need_txt ? TXT_DATA : `IPSC_PAD_BYTE;
  wire [7:0]  trl_byte   = (cnt_r == 8'h0) ? {cs_r[6], cs_r[6:0]}
                                           : op_byte({1'b0, valid_n[5:0]});
  wire [7:0]  out_byte   = (st_r == IPSC_ST_VPIX) ? VID_DATA :
                           (st_r == IPSC_ST_TDAT) ? tdat_byte :
                           (st_r == IPSC_ST_TTRL) ? trl_byte : head_byte;
  wire        emit = adv & ((st_r == IPSC_ST_PRE) | (st_r == IPSC_ST_HDR) |
                            (st_r == IPSC_ST_TTRL) | (st_r == IPSC_ST_VPIX & VID_VALID) |
                            (st_r == IPSC_ST_TDAT & (~need_txt | TXT_VALID)));
  wire        code_ev = emit & (st_r == IPSC_ST_PRE) & (cnt_r == 8'h3);
  wire        vstart  = CE & (st_r == IPSC_ST_IDLE) & VID_LINE_REQ;
  wire        sav_ev  = (code_ev & ~txt_r & ~eav_r) | (vstart & ~codes_en);
  wire        pix_end = emit & (st_r == IPSC_ST_VPIX) & VID_END;
  wire        cs_add  = emit & txt_r & ((st_r == IPSC_ST_HDR) | (st_r == IPSC_ST_TDAT) |
                                        (code_ev & ~eav_r));

  assign VID_READY = adv & (st_r == IPSC_ST_VPIX);
  assign TXT_READY = adv & need_txt;
  assign TXT_DONE  = emit & (st_r == IPSC_ST_TTRL) & (cnt_r == 8'h1);

  // ******************************************************************
  // Arbiter and framing sequencer
  // ******************************************************************
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    eav_nxt = eav_r;
    txt_nxt = txt_r;
    case (st_r)
      IPSC_ST_IDLE: begin
        cnt_nxt = 8'h0;
        eav_nxt = 1'b0;
        if (VID_LINE_REQ) begin
          txt_nxt = 1'b0;
          st_nxt  = codes_en ? IPSC_ST_PRE : IPSC_ST_VPIX;
        end else if (TXT_REQ && !VID_FIFO_PENDING) begin
          txt_nxt = 1'b1;
          st_nxt  = (codes_en || did_anc) ? IPSC_ST_PRE : IPSC_ST_HDR;
        end
      end
      IPSC_ST_PRE: begin
        if (emit) begin
          cnt_nxt = cnt_r + 8'h1;
          if (cnt_r == 8'h3) begin
            cnt_nxt = 8'h0;
            st_nxt  = eav_r ? IPSC_ST_IDLE : (txt_r ? IPSC_ST_HDR : IPSC_ST_VPIX);
          end
        end
      end
      IPSC_ST_VPIX: begin
        if (pix_end) begin
          eav_nxt = 1'b1;
          st_nxt  = codes_en ? IPSC_ST_PRE : IPSC_ST_IDLE;
        end
      end
      IPSC_ST_HDR: begin
        if (emit) begin
          cnt_nxt = (cnt_r == 8'h1) ? 8'h0 : cnt_r + 8'h1;
          if (cnt_r == 8'h1) st_nxt = IPSC_ST_TDAT;
        end
      end
      IPSC_ST_TDAT: begin
        if (emit) begin
          cnt_nxt = (cnt_r == region_end) ? 8'h0 : cnt_r + 8'h1;
          if (cnt_r == region_end) st_nxt = IPSC_ST_TTRL;
        end
      end
      IPSC_ST_TTRL: begin
        if (emit) begin
          cnt_nxt = cnt_r + 8'h1;
          if (cnt_r == 8'h1) begin
            cnt_nxt = 8'h0;
            eav_nxt = 1'b1;
            st_nxt  = (codes_en && !anc_r) ? IPSC_ST_PRE : IPSC_ST_IDLE;
          end
        end
      end
      default: st_nxt = IPSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_r  <= IPSC_ST_IDLE;
      cnt_r <= 8'h0;
      eav_r <= 1'b0;
      txt_r <= 1'b0;
    end else if (CE) begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      eav_r <= eav_nxt;
      txt_r <= txt_nxt;
    end
  end

  // Line attributes are caught when the arbiter takes a line
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      anc_r  <= 1'b0;
      msb_r  <= 1'b0;
      fid_r  <= 1'b0;
      vbl_r  <= 1'b0;
      last_r <= 1'b0;
    end else if (CE && st_r == IPSC_ST_IDLE) begin
      anc_r  <= ~VID_LINE_REQ & did_anc;
      msb_r  <= VID_LINE_REQ ? vid_msb : (did_r == `IPSC_DID_MSB1);
      fid_r  <= VID_LINE_REQ ? VID_FIELD : TXT_FIELD;
      vbl_r  <= VID_LINE_VBLANK;
      last_r <= VID_LINE_LAST;
    end
  end

  // ******************************************************************
  // Output byte, checksum and reference signals
  // ******************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      data_r    <= `IPSC_BYTE_INVALID;
      qual_r    <= 1'b0;
      cs_r      <= 8'h0;
      tfirst_r  <= 1'b0;
      sl_flag_r <= 1'b0;
      hgate_r   <= 1'b0;
      vgate_r   <= 1'b0;
      hprev_r   <= 1'b0;
      vprev_r   <= 1'b0;
    end else if (CE) begin
      data_r  <= emit ? out_byte : `IPSC_BYTE_INVALID;
      qual_r  <= emit;
      if (st_r == IPSC_ST_IDLE)
        cs_r <= 8'h0;
      else if (cs_add)
        cs_r <= cs_r + out_byte;
      tfirst_r <= (st_r == IPSC_ST_IDLE) ? (TXT_REQ & ~VID_LINE_REQ) : tfirst_r & ~emit;
      if (emit && txt_r && tfirst_r)
        sl_flag_r <= 1'b1;
      else if (sav_ev)
        sl_flag_r <= 1'b0;
      hgate_r <= (st_r == IPSC_ST_VPIX);
      if (pix_end && last_r)
        vgate_r <= 1'b0;
      else if (st_r == IPSC_ST_VPIX && !vbl_r)
        vgate_r <= 1'b1;
      hprev_r <= hgate_r;
      vprev_r <= vgate_r;
    end
  end

  // Pins are flop outputs through trigger edge detect, polarity and mapping only
  wire trig_mode = ctrl_r[`IPSC_CTRL_TRIG];
  wire h_ref     = trig_mode ? (hgate_r & ~hprev_r) : hgate_r;
  wire v_ref     = trig_mode ? (vgate_r & ~vprev_r) : vgate_r;

  assign PORT_DATA            = data_r;
  assign OUTPUT_QUALIFIER_PIN = qual_r ^ pol_r[0];
  assign HORIZONTAL_GATE_PIN  = h_ref ^ pol_r[1];
  assign VERTICAL_GATE_PIN    = v_ref ^ pol_r[2];
  assign GENERAL_FLAG_PIN_A   = flag_mux(fsel_r[1:0], sl_flag_r, h_ref, v_ref, qual_r) ^ pol_r[3];
  assign GENERAL_FLAG_PIN_B   = flag_mux(fsel_r[3:2], sl_flag_r, h_ref, v_ref, qual_r) ^ pol_r[4];

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  wire bus_wr = AVS_WRITE & ~AVS_WAITREQUEST;

  a_invalid_zero: assert property (!qual_r |-> data_r == 8'h00)
    else $error("unqualified cycle carries nonzero byte");
  a_text_after_line: assert property (CE && st_r == IPSC_ST_IDLE && VID_LINE_REQ
                                      |=> !txt_r)
    else $error("text started while a video line was waiting");
  a_preamble_order: assert property (emit && st_r == IPSC_ST_PRE && !anc_r && cnt_r != 8'h3
                                     |=> PORT_DATA == (($past(cnt_r) == 8'h0) ? 8'hff : 8'h00))
    else $error("timing code preamble byte wrong");
  a_dword_count: assert property (emit && st_r == IPSC_ST_HDR && cnt_r == 8'h1 && !anc_r
                                  |=> PORT_DATA == 8'h4b)
    else $error("code framing dword count is not 4B");
  a_pad_fill: assert property (emit && st_r == IPSC_ST_TDAT && !anc_r && cnt_r >= valid_n
                               |=> PORT_DATA == 8'ha0 && qual_r)
    else $error("pad byte is not A0");
  a_video_msb: assert property (code_ev && !txt_r
                                |=> PORT_DATA[7] == $past(msb_r))
    else $error("video code MSB does not follow page select");
  a_text_msb: assert property (code_ev && txt_r && !anc_r && !bus_wr
                               |=> PORT_DATA[7] == (did_r == 6'h3e))
    else $error("text code MSB does not follow the ancillary id");
  a_burst_keep: assert property (CE && adv && burst_r == 8'h0 && BURST_LEN > 1 && CE
                                 ##1 CE |-> adv)
    else $error("burst ended after one cycle");
  a_sliced_clear: assert property (CE && sav_ev && !(emit && txt_r && tfirst_r)
                                   |=> !sl_flag_r)
    else $error("sliced flag survived a start code");
  a_trig_pulse: assert property (CE && trig_mode && !pol_r[1] && HORIZONTAL_GATE_PIN && !bus_wr
                                 |=> !HORIZONTAL_GATE_PIN)
    else $error("horizontal trigger longer than one cycle");

  c_video_line: cover property (code_ev && !txt_r && eav_r);
  c_text_codes: cover property (TXT_DONE && !anc_r);
  c_text_anc:   cover property (TXT_DONE && anc_r);
  c_gate_stall: cover property (st_r == IPSC_ST_TDAT && !adv && CE);

endmodule

`default_nettype wire
